// ---- core/aei_flag_bank.sv ----
// Per-channel early-interrupt flags and forwarded request pulses.
// Assumes event and buffer-read inputs are one-cycle synchronous pulses.
`timescale 1ns/1ns
`default_nettype none
`include "aei_consts.svh"

module aei_flag_bank #(
   parameter int NUM_CH = `AEI_NUM_CH   // Number of analog channels.
) (
   input  wire logic              i_clk,     // Bus clock.
   input  wire logic              i_rst,     // Asynchronous reset.
   input  wire logic [NUM_CH-1:0] i_evt,     // Raw early events.
   input  wire logic [NUM_CH-1:0] i_en,      // Early-interrupt enables.
   input  wire logic [NUM_CH-1:0] i_buf_rd,  // Result buffer was read.
   input  wire logic [NUM_CH-1:0] i_sw_clr,  // Software one-to-clear.
   output logic      [NUM_CH-1:0] o_flag,    // Sticky flags.
   output logic      [NUM_CH-1:0] o_req      // Forwarded requests.
);

   genvar k;

   // Each channel has its own flag and request flip-flop.
   generate
      for (k = 0; k < NUM_CH; k++) begin : g_ch
         logic fire;     // Enabled event this cycle.
         logic flag_d;   // Next flag.
         logic flag_q;   // Flag.
         logic req_q;    // Registered request pulse.

         // An event counts only while its channel is enabled.
         assign fire = i_evt[k] & i_en[k];

         // A new event beats a clear in the same cycle, so none is lost.
         always_comb begin
            flag_d = fire | (flag_q & ~(i_buf_rd[k] | i_sw_clr[k]));
         end

         // Flag and request registers.
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               flag_q <= 1'b0;
               req_q  <= 1'b0;
            end else begin
               flag_q <= flag_d;
               req_q  <= fire;
            end
         end

         assign o_flag[k] = flag_q;
         assign o_req[k]  = req_q;
      end
   endgenerate

endmodule

`default_nettype wire

// ---- core/aei_reg_bank.sv ----
// Top of the early-interrupt and input-mode register bank.
// Assumes a classic Wishbone master on the bus clock and synchronous
// event and buffer-read pulses from the converter side.
`timescale 1ns/1ns
`default_nettype none
`include "aei_consts.svh"

// Notes on behaviour
// - One enable bit per channel, low/high.
// - Flag sets when a channel's early interrupt fires.
// - Result buffer read clears that channel's flag.
// - High registers bits 15..6 read zero, ignore writes.
// - Odd bit 2k+1 selects differential for channel k.
// - Even bit 2k selects signed output for channel k.
module aei_reg_bank #(
   parameter int NUM_CH  = `AEI_NUM_CH,   // Analog channels in total.
   parameter int MODE_CH = `AEI_MODE_CH   // Channels with mode bits here.
) (
   input  wire logic                  I_CLK,            // Bus clock.
   input  wire logic                  I_RST,            // Async reset.
   input  wire logic                  I_WB_CYC,         // Bus cycle.
   input  wire logic                  I_WB_STB,         // Strobe.
   input  wire logic                  I_WB_WE,          // Write enable.
   input  wire logic [`AEI_ADR_W-1:0] I_WB_ADR,         // Byte address.
   input  wire logic [3:0]            I_WB_SEL,         // Byte lanes.
   input  wire logic [31:0]           I_WB_DAT,         // Write data.
   output logic      [31:0]           O_WB_DAT,         // Read data.
   output logic                       O_WB_ACK,         // Acknowledge.
   input  wire logic [NUM_CH-1:0]     I_EARLY_EVT,      // Early events.
   input  wire logic [NUM_CH-1:0]     I_BUF_RD,         // Buffer reads.
   output logic      [NUM_CH-1:0]     O_EARLY_REQ,      // Requests out.
   output logic      [MODE_CH-1:0]    O_PAIR_INPUT_SEL, // Differential.
   output logic      [MODE_CH-1:0]    O_SIGNED_OUT,     // Signed result.
   output logic                       O_IRQ             // Interrupt.
);
   import aei_pkg::*;

   // Channels that live in the high enable and flag registers.
   localparam int HI_CH = NUM_CH - `AEI_LO_CH;
   // Width of the input-mode register.
   localparam int MODE_W = MODE_CH * `AEI_MODE_STRIDE;

   // Builds a 16-bit lane mask from the two low byte selects.
   function automatic aei_half_t lane_mask(input logic [1:0] sel);
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Replaces the selected byte lanes of a value with new data.
   function automatic aei_half_t merge(input aei_half_t old_v,
                                       input aei_half_t new_v,
                                       input logic [1:0] sel);
      aei_half_t m;
      m     = lane_mask(sel);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   aei_wb_req_s            req;        // Request as one bundle.
   logic                   wb_load;    // Capture read data this edge.
   logic                   wb_wr;      // Write takes effect this edge.
   aei_reg_e               wb_reg;     // Decoded register.
   aei_half_t              wdat;       // Low half of write data.
   aei_half_t              wmask;      // Lanes that are written.

   logic [`AEI_LO_CH-1:0]  eie_lo_q;   // Enables, channels 0..15.
   logic [`AEI_LO_CH-1:0]  eie_lo_d;   // Next low enables.
   logic [HI_CH-1:0]       eie_hi_q;   // Enables, channels 16 and up.
   logic [HI_CH-1:0]       eie_hi_d;   // Next high enables.
   logic [MODE_W-1:0]      mode_q;     // Input-mode register.
   logic [MODE_W-1:0]      mode_d;     // Next input-mode value.
   logic [31:0]            rdata_q;    // Registered read data.
   logic [31:0]            rdata_d;    // Next read data.
   logic [31:0]            rd_mux;     // Value of the addressed register.
   aei_half_t              hi_wr;      // High write data after merge.

   logic [NUM_CH-1:0]      en_all;     // All enables side by side.
   logic [NUM_CH-1:0]      flags;      // All sticky flags.
   logic [NUM_CH-1:0]      sw_clr;     // Software one-to-clear vector.
   aei_half_t              clr_lo;     // Clear bits for low flags.
   aei_half_t              clr_hi;     // Clear bits for high flags.

   // Bundle the bus signals; the master holds them for the whole cycle.
   assign req.adr = I_WB_ADR;
   assign req.we  = I_WB_WE;
   assign req.sel = I_WB_SEL;
   assign req.dat = I_WB_DAT;

   // Only the low half of the word carries register bits.
   assign wdat  = I_WB_DAT[15:0];
   assign wmask = lane_mask(I_WB_SEL[1:0]);

   // Bus slave front end with a registered acknowledge.
   aei_wb_slave u_wb (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_cyc  (I_WB_CYC),
      .i_stb  (I_WB_STB),
      .i_req  (req),
      .o_ack  (O_WB_ACK),
      .o_load (wb_load),
      .o_wr   (wb_wr),
      .o_reg  (wb_reg)
   );

   // Enables form one vector, channel 0 in bit 0.
   assign en_all = {eie_hi_q, eie_lo_q};

   // Writing ones to a flag register clears those flags; writing zeros
   // does nothing, so software cannot fake an event by a write.
   always_comb begin
      clr_lo = `AEI_RST_REG16;
      clr_hi = `AEI_RST_REG16;
      if (wb_wr && wb_reg == AEI_REG_FLG_LO) begin
         clr_lo = wdat & wmask;
      end
      if (wb_wr && wb_reg == AEI_REG_FLG_HI) begin
         clr_hi = wdat & wmask & `AEI_HI_MASK;
      end
   end

   assign sw_clr = {clr_hi[HI_CH-1:0], clr_lo};

   // Flags and request pulses for every channel.
   aei_flag_bank #(
      .NUM_CH (NUM_CH)
   ) u_flags (
      .i_clk    (I_CLK),
      .i_rst    (I_RST),
      .i_evt    (I_EARLY_EVT),
      .i_en     (en_all),
      .i_buf_rd (I_BUF_RD),
      .i_sw_clr (sw_clr),
      .o_flag   (flags),
      .o_req    (O_EARLY_REQ)
   );

   // Next values of the software-written registers.
   always_comb begin
      eie_lo_d = eie_lo_q;
      eie_hi_d = eie_hi_q;
      mode_d   = mode_q;
      hi_wr    = `AEI_RST_REG16;
      if (wb_wr) begin
         case (wb_reg)
            AEI_REG_EIE_LO: begin
               eie_lo_d = merge(eie_lo_q, wdat, I_WB_SEL[1:0]);
            end
            AEI_REG_EIE_HI: begin
               // Bits above the implemented ones are dropped here.
               hi_wr    = merge(16'(eie_hi_q), wdat, I_WB_SEL[1:0]);
               hi_wr    = hi_wr & `AEI_HI_MASK;
               eie_hi_d = hi_wr[HI_CH-1:0];
            end
            AEI_REG_MODE: begin
               mode_d = merge(mode_q, wdat, I_WB_SEL[1:0]);
            end
            default: begin
               // Flag writes act through the clear vector; unmapped
               // writes are acknowledged and have no effect.
               eie_lo_d = eie_lo_q;
            end
         endcase
      end
   end

   // Software-written registers; all clear to zero at reset.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         eie_lo_q <= `AEI_RST_REG16;
         eie_hi_q <= '0;
         mode_q   <= `AEI_RST_REG16;
      end else begin
         eie_lo_q <= eie_lo_d;
         eie_hi_q <= eie_hi_d;
         mode_q   <= mode_d;
      end
   end

   // Value of the addressed register, zero-extended to the bus word.
   // Unimplemented high bits and unmapped addresses read as zero.
   always_comb begin
      case (wb_reg)
         AEI_REG_EIE_LO: rd_mux = 32'(eie_lo_q);
         AEI_REG_EIE_HI: rd_mux = 32'(eie_hi_q);
         AEI_REG_FLG_LO: rd_mux = 32'(flags[`AEI_LO_CH-1:0]);
         AEI_REG_FLG_HI: rd_mux = 32'(flags[NUM_CH-1:`AEI_LO_CH]);
         AEI_REG_MODE:   rd_mux = 32'(mode_q);
         default:        rd_mux = `AEI_RST_WORD;
      endcase
   end

   // Read data is captured one edge before the ack and held with it.
   // A flag that clears in the ack cycle still reads as it was.
   always_comb begin
      rdata_d = rdata_q;
      if (wb_load) begin
         rdata_d = rd_mux;
      end
   end

   // Read-data register.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdata_q <= `AEI_RST_WORD;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign O_WB_DAT = rdata_q;

   // Spread the paired mode bits onto one output per channel.
   genvar c;
   generate
      for (c = 0; c < MODE_CH; c++) begin : g_mode
         // Odd position: differential pair input.
         assign O_PAIR_INPUT_SEL[c] =
            mode_q[c * `AEI_MODE_STRIDE + `AEI_MODE_PAIR_INPUT_SELECT_POS];
         // Even position: signed result format.
         assign O_SIGNED_OUT[c] =
            mode_q[c * `AEI_MODE_STRIDE + `AEI_MODE_SIGN_POS];
      end
   endgenerate

   // The enables double as the interrupt mask; the line stays high
   // while any enabled flag is set, with no extra latency.
   assign O_IRQ = |(flags & en_all);

endmodule

`default_nettype wire

// ---- core/aei_wb_slave.sv ----
// Classic Wishbone slave front end: registered acknowledge and decode.
// Assumes a master that holds its request until it sees the acknowledge.
`timescale 1ns/1ns
`default_nettype none

module aei_wb_slave (
   input  wire logic                i_clk,      // Bus clock.
   input  wire logic                i_rst,      // Asynchronous reset.
   input  wire logic                i_cyc,      // Bus cycle.
   input  wire logic                i_stb,      // Strobe.
   input  wire aei_pkg::aei_wb_req_s i_req,     // Held request.
   output logic                     o_ack,      // Acknowledge.
   output logic                     o_load,     // Capture read data now.
   output logic                     o_wr,       // Write takes effect now.
   output aei_pkg::aei_reg_e        o_reg       // Decoded register.
);
   import aei_pkg::*;

   aei_wb_st_e st_q;   // Current slave state.
   aei_wb_st_e st_d;   // Next slave state.
   logic       req;    // A request is on the bus.

   assign req = i_cyc & i_stb;

   // One idle cycle then one acknowledge cycle; the ack drops by itself
   // so a request that stays up does not get a second answer early.
   always_comb begin
      st_d = st_q;
      case (st_q)
         AEI_WB_IDLE: begin
            if (req) begin
               st_d = AEI_WB_ACK;
            end
         end
         AEI_WB_ACK: begin
            st_d = AEI_WB_IDLE;
         end
         default: begin
            st_d = AEI_WB_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= AEI_WB_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // The write lands on the edge where the master samples the ack.
   assign o_ack  = (st_q == AEI_WB_ACK);
   assign o_load = req & (st_q == AEI_WB_IDLE);
   assign o_wr   = req & i_req.we & (st_q == AEI_WB_ACK);
   assign o_reg  = aei_decode(i_req.adr);

endmodule

`default_nettype wire

// ---- inc/aei_consts.svh ----
// Named constants for the early-interrupt and input-mode register bank.
// Assumes it is included by bare name wherever the names are needed.
`ifndef AEI_CONSTS_SVH
`define AEI_CONSTS_SVH

// Width of the Wishbone byte address seen by the bank.
`define AEI_ADR_W          8

// Byte offsets of the five registers, one aligned 32-bit word each.
`define AEI_OFS_EIE_LO     8'h00
`define AEI_OFS_EIE_HI     8'h04
`define AEI_OFS_FLG_LO     8'h08
`define AEI_OFS_FLG_HI     8'h0c
`define AEI_OFS_MODE       8'h10

// Reset values of a 16-bit register and of the read-data word.
`define AEI_RST_REG16      16'h0000
`define AEI_RST_WORD       32'h0000_0000

// Implemented bits of the high enable and high flag registers.
`define AEI_HI_MASK        16'h003f

// Layout of the input-mode register: two bits per channel.
`define AEI_MODE_STRIDE    2
`define AEI_MODE_PAIR_INPUT_SELECT_POS  1
`define AEI_MODE_SIGN_POS  0

// Channel counts.
`define AEI_NUM_CH         22
`define AEI_LO_CH          16
`define AEI_MODE_CH        8

`endif

// ---- inc/aei_pkg.sv ----
// Types and decode helpers shared by the register bank files.
// Assumes the constants header is reachable on the include path.
`include "aei_consts.svh"

package aei_pkg;

   // One Wishbone request as the master holds it during a cycle.
   typedef struct packed {
      logic [`AEI_ADR_W-1:0] adr;   // Byte address.
      logic                  we;    // High for a write.
      logic [3:0]            sel;   // Byte lane selects.
      logic [31:0]           dat;   // Write data.
   } aei_wb_req_s;

   // Register chosen by an address; none for an unmapped one.
   typedef enum logic [2:0] {
      AEI_REG_EIE_LO,
      AEI_REG_EIE_HI,
      AEI_REG_FLG_LO,
      AEI_REG_FLG_HI,
      AEI_REG_MODE,
      AEI_REG_NONE
   } aei_reg_e;

   // States of the bus slave.
   typedef enum logic {
      AEI_WB_IDLE,
      AEI_WB_ACK
   } aei_wb_st_e;

   // A 16-bit register value.
   typedef logic [15:0] aei_half_t;

   // Maps a byte address onto a register; low address bits must be zero.
   function automatic aei_reg_e aei_decode(input logic [`AEI_ADR_W-1:0] adr);
      case (adr)
         `AEI_OFS_EIE_LO: aei_decode = AEI_REG_EIE_LO;
         `AEI_OFS_EIE_HI: aei_decode = AEI_REG_EIE_HI;
         `AEI_OFS_FLG_LO: aei_decode = AEI_REG_FLG_LO;
         `AEI_OFS_FLG_HI: aei_decode = AEI_REG_FLG_HI;
         `AEI_OFS_MODE:   aei_decode = AEI_REG_MODE;
         default:         aei_decode = AEI_REG_NONE;
      endcase
   endfunction

endpackage

// ---- verification/aei_reg_bank_sva.sv ----
// Checker for the early-interrupt and input-mode register bank.
// Assumes it is bound to the bank's top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "aei_consts.svh"

module aei_reg_bank_sva #(
   parameter int NUM_CH  = 22,   // Analog channels in total.
   parameter int MODE_CH = 8     // Channels with mode bits.
) (
   input wire logic                  I_CLK,
   input wire logic                  I_RST,
   input wire logic                  I_WB_CYC,
   input wire logic                  I_WB_STB,
   input wire logic                  I_WB_WE,
   input wire logic [`AEI_ADR_W-1:0] I_WB_ADR,
   input wire logic [3:0]            I_WB_SEL,
   input wire logic [31:0]           I_WB_DAT,
   input wire logic [31:0]           O_WB_DAT,
   input wire logic                  O_WB_ACK,
   input wire logic [NUM_CH-1:0]     I_EARLY_EVT,
   input wire logic [NUM_CH-1:0]     I_BUF_RD,
   input wire logic [NUM_CH-1:0]     O_EARLY_REQ,
   input wire logic [MODE_CH-1:0]    O_PAIR_INPUT_SEL,
   input wire logic [MODE_CH-1:0]    O_SIGNED_OUT,
   input wire logic                  O_IRQ
);
   logic [MODE_CH-1:0] odd_w;    // Odd write-data bits, one per channel.
   logic [MODE_CH-1:0] even_w;   // Even write-data bits, one per channel.

   // Split the write data into the two per-channel mode fields.
   always_comb begin
      for (int k = 0; k < MODE_CH; k++) begin
         odd_w[k]  = I_WB_DAT[2*k+1];
         even_w[k] = I_WB_DAT[2*k];
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   // A fresh request: strobe up while the slave is not answering.
   sequence s_req_new;
      I_WB_CYC && I_WB_STB && !O_WB_ACK;
   endsequence

   // The answered write to the mode register with both low lanes on.
   sequence s_mode_wr;
      O_WB_ACK && I_WB_WE && I_WB_ADR == `AEI_OFS_MODE &&
         I_WB_SEL[1:0] == 2'b11;
   endsequence

   a_ack_next: assert property (s_req_new |=> O_WB_ACK)
      else $error("ack missing one cycle after a request");
   a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack held longer than one cycle");
   a_req_cause:
      assert property ((O_EARLY_REQ & ~$past(I_EARLY_EVT)) == '0)
      else $error("request without an event");
   a_req_irq:
      assert property (((O_EARLY_REQ != '0) &&
         !$past(O_WB_ACK && I_WB_WE && (I_WB_ADR == `AEI_OFS_EIE_LO ||
         I_WB_ADR == `AEI_OFS_EIE_HI))) |-> O_IRQ)
      else $error("request forwarded without a pending flag");
   a_bufrd_clr:
      assert property ((I_BUF_RD == '1 && I_EARLY_EVT == '0) |=> !O_IRQ)
      else $error("buffer reads left a flag standing");
   a_hi_zero:
      assert property ((O_WB_ACK && !I_WB_WE &&
         (I_WB_ADR == `AEI_OFS_EIE_HI || I_WB_ADR == `AEI_OFS_FLG_HI))
         |-> O_WB_DAT[31:6] == '0)
      else $error("high register read unused bits as one");
   a_mode_pair_input_select:
      assert property (s_mode_wr |=> O_PAIR_INPUT_SEL == $past(odd_w))
      else $error("differential select differs from odd bits");
   a_mode_sign:
      assert property (s_mode_wr |=> O_SIGNED_OUT == $past(even_w))
      else $error("signed select differs from even bits");
   a_mode_hold:
      assert property (($changed(O_PAIR_INPUT_SEL) ||
         $changed(O_SIGNED_OUT)) |-> $past(O_WB_ACK && I_WB_WE &&
         I_WB_ADR == `AEI_OFS_MODE))
      else $error("mode outputs moved without a mode write");
   a_irq_rise:
      assert property ($rose(O_IRQ) |-> (O_EARLY_REQ != '0 ||
         $past(O_WB_ACK && I_WB_WE)))
      else $error("interrupt rose without an enabled event");
endmodule
`default_nettype wire

// ---- verification/tb_aei_reg_bank.sv ----
// Self-checking bench for the early-interrupt and input-mode bank.
// Assumes the bank and its checker are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`include "aei_consts.svh"

module tb_aei_reg_bank;
   localparam int NCH = 22;        // Channels in total.
   logic           clk;            // Bus clock, 40 ns period.
   logic           rst;            // Asynchronous reset.
   logic           cyc;            // Wishbone cycle.
   logic           stb;            // Wishbone strobe.
   logic           we;             // Write enable.
   logic [7:0]     adr;            // Byte address.
   logic [3:0]     sel;            // Byte lanes.
   logic [31:0]    wdat;           // Write data.
   logic [31:0]    rdat;           // Read data from the bank.
   logic           ack;            // Acknowledge.
   logic [NCH-1:0] evt;            // Early events.
   logic [NCH-1:0] bufrd;          // Result buffer reads.
   logic [NCH-1:0] req;            // Forwarded requests.
   logic [7:0]     pair;           // Differential selects.
   logic [7:0]     sgn;            // Signed selects.
   logic           irq;            // Interrupt line.
   int             bad_count;      // Mismatches seen.
   int             tests_run;      // Comparisons made.

   aei_reg_bank #(.NUM_CH(NCH), .MODE_CH(8)) aei_reg_bank_i (
      .I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EARLY_EVT(evt),
      .I_BUF_RD(bufrd), .O_EARLY_REQ(req), .O_PAIR_INPUT_SEL(pair),
      .O_SIGNED_OUT(sgn), .O_IRQ(irq));

   // Free-running bus clock.
   initial clk = 1'b0;
   always #20 clk = ~clk;

   // Compares a value read over the bus.
   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected read at %0t: %h exp %h", $time, got, exp);
      end
   endtask

   // Compares a value seen on output pins.
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected pins at %0t: %h exp %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request is held until ack is seen at a
   // rising edge, so a slow answer is waited for rather than assumed.
   // Only the watchdog ends a wait that never gets its answer.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      // The write lands and the read data is taken at this very edge.
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // Register write and checked register read.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk_bus(q, exp);
   endtask

   // One-cycle pulse on the converter side, then settle.
   task automatic pulse(input logic [NCH-1:0] e, input logic [NCH-1:0] r);
      @(posedge clk);
      evt <= e;
      bufrd <= r;
      @(posedge clk);
      evt <= '0;
      bufrd <= '0;
      @(negedge clk);
   endtask

   // Every register, and the unmapped word at 0x14, reads zero after reset.
   task automatic t_reset();
      for (int a = 0; a <= 'h14; a += 4)
         rd(8'(a), 32'h0);
      @(negedge clk);
      chk_pin(32'(irq), 32'h0);
      chk_pin({16'h0, pair, sgn}, 32'h0);
      $display("test reset done");
   endtask

   // Enables hold what is written; high halves keep only six bits.
   task automatic t_regs();
      wr(`AEI_OFS_EIE_LO, 16'hffff);
      rd(`AEI_OFS_EIE_LO, 32'h0000_ffff);
      wr(`AEI_OFS_EIE_HI, 16'hffff);
      rd(`AEI_OFS_EIE_HI, 32'h0000_003f);
      wr(`AEI_OFS_FLG_HI, 16'hffff);
      rd(`AEI_OFS_FLG_HI, 32'h0);
      wr(8'h14, 16'hffff);
      rd(8'h14, 32'h0);
      wr(`AEI_OFS_EIE_LO, 16'h0000);
      rd(`AEI_OFS_EIE_LO, 32'h0);
      wr(`AEI_OFS_EIE_HI, 16'h0000);
      $display("test regs done");
   endtask

   // Events on all channels; only enabled ones flag and forward.
   task automatic t_flags();
      wr(`AEI_OFS_EIE_LO, 16'h0005);
      wr(`AEI_OFS_EIE_HI, 16'h0020);
      pulse('1, '0);
      chk_pin(32'(req), 32'h0020_0005);
      chk_pin(32'(irq), 32'h1);
      rd(`AEI_OFS_FLG_LO, 32'h0005);
      rd(`AEI_OFS_FLG_HI, 32'h0020);
      pulse('0, 22'h00_0001);
      chk_pin(32'(req), 32'h0);
      rd(`AEI_OFS_FLG_LO, 32'h0004);
      wr(`AEI_OFS_EIE_HI, 16'h0000);
      rd(`AEI_OFS_FLG_HI, 32'h0020);
      wr(`AEI_OFS_EIE_LO, 16'h0000);
      @(negedge clk) chk_pin(32'(irq), 32'h0);
      wr(`AEI_OFS_EIE_LO, 16'h0005);
      @(negedge clk) chk_pin(32'(irq), 32'h1);
      wr(`AEI_OFS_FLG_LO, 16'h0004);
      rd(`AEI_OFS_FLG_LO, 32'h0);
      pulse('0, '1);
      rd(`AEI_OFS_FLG_HI, 32'h0);
      @(negedge clk);
      chk_pin(32'(irq), 32'h0);
      // An event and a buffer read in one cycle: the event wins.
      pulse(22'h00_0001, 22'h00_0001);
      chk_pin(32'(req), 32'h1);
      rd(`AEI_OFS_FLG_LO, 32'h0001);
      $display("test flags done");
   endtask

   // Walk a single one through the mode register.
   task automatic t_mode();
      logic [7:0] exp;
      for (int i = 0; i < 16; i++) begin
         wr(`AEI_OFS_MODE, 16'h0001 << i);
         rd(`AEI_OFS_MODE, 32'h1 << i);
         exp = 8'h01 << (i / 2);
         @(negedge clk);
         chk_pin(32'(pair), (i % 2) ? 32'(exp) : 32'h0);
         chk_pin(32'(sgn), (i % 2) ? 32'h0 : 32'(exp));
      end
      $display("test mode done");
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: reset for two cycles, then the scenarios.
   initial begin
      bad_count = 0;
      tests_run = 0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      evt = '0;
      bufrd = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_flags();
      t_mode();
      end_sim();
   end

   // Watchdog: the scenarios need well under a thousand cycles.
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule

bind aei_reg_bank aei_reg_bank_sva #(.NUM_CH(NUM_CH), .MODE_CH(MODE_CH))
   aei_reg_bank_sva_i (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
   .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
   .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .I_EARLY_EVT(I_EARLY_EVT), .I_BUF_RD(I_BUF_RD),
   .O_EARLY_REQ(O_EARLY_REQ), .O_PAIR_INPUT_SEL(O_PAIR_INPUT_SEL),
   .O_SIGNED_OUT(O_SIGNED_OUT), .O_IRQ(O_IRQ));
`default_nettype wire
